// ==== common/reset_select_regs_defines.svh ====
// What this block does
// RULE_01 - clear requests, hardware or software, act only while clear enable is set
// RULE_02 - writing software clear trigger clears data to chosen value, then self-clears
// RULE_03 - clear value select: 0 loads zero scale, 1 loads mid scale
// RULE_04 - power-off condition bit picks output state at power-up and reset
// RULE_05 - writing loopback user bit copies its value to toggle status bit
// RULE_06 - reference enable bit turns internal reference on when set
// RULE_07 - pass-through bit places serial interface in transparent mode
// RULE_08 - three user bits hold last written value, reset to zero
// RULE_09 - serial output disable stops forwarding and floats serial data output
// RULE_10 - frame check enable switches on incoming frame error checking
// RULE_11 - watchdog period field selects 10, 51, 102 or 204 ms timeout
// RULE_12 - watchdog runs only while watchdog enable bit is set
// RULE_13 - software selects channel before touching per-channel registers
// RULE_14 - software reset restores defaults except power-off condition bit
// RULE_15 - software clear needs clear enable; reserved bits store and read back
`ifndef RESET_SELECT_REGS_DEFINES_SVH
`define RESET_SELECT_REGS_DEFINES_SVH
`define ADDR_RESET_CFG 8'h02
`define ADDR_SELECT 8'h03
`define ADDR_SOFT_RESET 8'h01
`define ADDR_STATUS 8'h0B
`define RESET_CFG_RST 16'h0000
`define SELECT_RST 16'h0000
`define BIT_USER_A 12
`define BIT_USER_B 11
`define BIT_USER_C 10
`define BIT_CLEAR_EN 9
`define BIT_REF_EN 4
`define BIT_PASS 3
`define BIT_SW_CLEAR 2
`define BIT_POWER_OFF 1
`define BIT_LOOPBACK 0
`define BIT_CLEAR_SEL 9
`define BIT_CHAN 5
`define BIT_SERIAL_OUT_DIS 4
`define BIT_FRAME_CHK 3
`define BIT_WDT_HI 2
`define BIT_WDT_LO 1
`define BIT_WDT_EN 0
`define BIT_TOGGLE_STAT 6
`define BIT_SOFT_RESET 0
`define CLEAR_ZERO 16'h0000
`define CLEAR_MID 16'h8000
`define WDT_MS_0 10
`define WDT_MS_1 51
`define WDT_MS_2 102
`define WDT_MS_3 204
`define CLK_HZ 20000000
`endif

// ==== common/reset_select_regs_pkg.sv ====
package reset_select_regs_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// ==== rtl/reset_select_regs.sv ====
`timescale 1ns/1ps
`include "reset_select_regs_defines.svh"
module reset_select_regs
  import reset_select_regs_pkg::*;
#(
  parameter int unsigned WDT_CYC_0 = (`WDT_MS_0 * (`CLK_HZ / 1000)),
  parameter int unsigned WDT_CYC_1 = (`WDT_MS_1 * (`CLK_HZ / 1000)),
  parameter int unsigned WDT_CYC_2 = (`WDT_MS_2 * (`CLK_HZ / 1000)),
  parameter int unsigned WDT_CYC_3 = (`WDT_MS_3 * (`CLK_HZ / 1000))
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic hwClearReq,
  output logic [15:0] regRdata,
  output logic clearPulse,
  output logic [15:0] clearValue,
  output logic userBitA,
  output logic userBitB,
  output logic userBitC,
  output logic refEnable,
  output logic passThrough,
  output logic powerOffCondition,
  output logic loopbackToggleStatus,
  output logic channelSelect,
  output logic serialOutEnableN,
  output logic frameCheckEnable,
  output logic watchdogEnable,
  output logic [31:0] watchdogPeriodCycles
);
  reg_req_s req;
  logic [15:0] cfg_q, cfg_d, sel_q, sel_d, rdata_q, rdata_d;
  logic tgl_q, tgl_d, pulse_q, pulse_d;
  logic [15:0] clrv_q, clrv_d;
  logic [31:0] wdp_q, wdp_d;
  logic softReset;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign softReset = req.wr && req.addr == `ADDR_SOFT_RESET
    && req.wdata[`BIT_SOFT_RESET];

  always_comb begin
    cfg_d = cfg_q;
    sel_d = sel_q;
    tgl_d = tgl_q;
    pulse_d = 1'b0;
    rdata_d = 16'h0000;
    if (softReset) begin
      // power-off condition survives a software reset
      cfg_d = `RESET_CFG_RST; // RULE_14
      cfg_d[`BIT_POWER_OFF] = cfg_q[`BIT_POWER_OFF]; // RULE_14
      sel_d = `SELECT_RST; // RULE_14
      tgl_d = 1'b0;
    end else if (req.wr && req.addr == `ADDR_RESET_CFG) begin
      cfg_d = req.wdata; // RULE_08 RULE_06 RULE_07 RULE_04 RULE_15
      tgl_d = req.wdata[`BIT_LOOPBACK]; // RULE_05
      // stored trigger bit self-clears; only a one-cycle pulse leaves
      cfg_d[`BIT_SW_CLEAR] = 1'b0; // RULE_02
    end else if (req.wr && req.addr == `ADDR_SELECT) begin
      sel_d = req.wdata; // RULE_09 RULE_10 RULE_12 RULE_15
    end
    if (!softReset && cfg_q[`BIT_CLEAR_EN]) begin
      pulse_d = hwClearReq; // RULE_01
    end
    if (!softReset && req.wr && req.addr == `ADDR_RESET_CFG
        && req.wdata[`BIT_SW_CLEAR] && cfg_q[`BIT_CLEAR_EN]) begin
      pulse_d = 1'b1; // RULE_02 RULE_15 RULE_01
    end
    clrv_d = sel_q[`BIT_CLEAR_SEL] ? `CLEAR_MID : `CLEAR_ZERO; // RULE_03
    unique case (sel_q[`BIT_WDT_HI:`BIT_WDT_LO]) // RULE_11
      2'b00: wdp_d = WDT_CYC_0;
      2'b01: wdp_d = WDT_CYC_1;
      2'b10: wdp_d = WDT_CYC_2;
      2'b11: wdp_d = WDT_CYC_3;
    endcase
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_RESET_CFG: rdata_d = cfg_q;
        `ADDR_SELECT: rdata_d = sel_q;
        `ADDR_STATUS: rdata_d[`BIT_TOGGLE_STAT] = tgl_q; // RULE_05
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= `RESET_CFG_RST;
      sel_q <= `SELECT_RST;
      tgl_q <= 1'b0;
      pulse_q <= 1'b0;
      clrv_q <= `CLEAR_ZERO;
      wdp_q <= 32'h0000_0000;
      rdata_q <= 16'h0000;
    end else begin
      cfg_q <= cfg_d;
      sel_q <= sel_d;
      tgl_q <= tgl_d;
      pulse_q <= pulse_d;
      clrv_q <= clrv_d;
      wdp_q <= wdp_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops; channel select is only a flag for
  // software sequencing, the bank itself holds no per-channel state
  assign regRdata = rdata_q;
  assign clearPulse = pulse_q;
  assign clearValue = clrv_q;
  assign userBitA = cfg_q[`BIT_USER_A];
  assign userBitB = cfg_q[`BIT_USER_B];
  assign userBitC = cfg_q[`BIT_USER_C];
  assign refEnable = cfg_q[`BIT_REF_EN];
  assign passThrough = cfg_q[`BIT_PASS];
  assign powerOffCondition = cfg_q[`BIT_POWER_OFF];
  assign loopbackToggleStatus = tgl_q;
  assign channelSelect = sel_q[`BIT_CHAN];
  assign serialOutEnableN = sel_q[`BIT_SERIAL_OUT_DIS];
  assign frameCheckEnable = sel_q[`BIT_FRAME_CHK];
  assign watchdogEnable = sel_q[`BIT_WDT_EN];
  assign watchdogPeriodCycles = wdp_q;
endmodule // reset_select_regs

// ==== testbench/reset_select_regs_asserts.sv ====
`timescale 1ns/1ps
module reset_select_regs_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic userBitA,
  input wire logic refEnable,
  input wire logic passThrough,
  input wire logic powerOffCondition,
  input wire logic loopbackToggleStatus,
  input wire logic serialOutEnableN,
  input wire logic frameCheckEnable,
  input wire logic watchdogEnable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire w2 = regWr && regAddr == 8'h02;
  wire w3 = regWr && regAddr == 8'h03;
  chk_ref_on: assert property (
    w2 |=> refEnable == $past(regWdata[4]))
    else $error("bad ref");
  chk_pass_mode: assert property (
    w2 |=> passThrough == $past(regWdata[3]))
    else $error("bad pass");
  chk_user_bit: assert property (
    w2 |=> userBitA == $past(regWdata[12]))
    else $error("bad user");
  chk_loop_copy: assert property (
    w2 |=> loopbackToggleStatus == $past(regWdata[0]))
    else $error("bad loop");
  chk_serial_float: assert property (
    w3 |=> serialOutEnableN == $past(regWdata[4]))
    else $error("bad serial out");
  chk_frame_chk: assert property (
    w3 |=> frameCheckEnable == $past(regWdata[3]))
    else $error("bad frame");
  chk_wdt_en: assert property (
    w3 |=> watchdogEnable == $past(regWdata[0]))
    else $error("bad wdt");
  // the power-off bit must survive a soft reset
  chk_soft_keep: assert property (regWr && regAddr == 8'h01 && regWdata[0] |=>
    $stable(powerOffCondition) && !refEnable)
    else $error("bad soft reset");
endmodule // reset_select_regs_asserts
bind reset_select_regs reset_select_regs_asserts i_chk (.*);

// ==== testbench/tb_reset_select_regs.sv ====
`timescale 1ns/1ps
module tb_reset_select_regs;
  logic clk_sys = 0, nrst = 0, regWr = 0, regRd = 0, hwClearReq = 0;
  logic [7:0] regAddr = 0;
  logic [15:0] regWdata = 0;
  wire [15:0] regRdata, clearValue;
  wire [31:0] watchdogPeriodCycles;
  wire clearPulse, userBitA, userBitB, userBitC, refEnable, passThrough;
  wire powerOffCondition, loopbackToggleStatus, channelSelect;
  wire serialOutEnableN, frameCheckEnable, watchdogEnable;
  int num_errors = 0, samples_checked = 0;
  reset_select_regs #(.WDT_CYC_0(10), .WDT_CYC_1(20), .WDT_CYC_2(30),
    .WDT_CYC_3(40)) i_reset_select_regs (.*);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // read when w is 0: d is the expected read data
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
    if (!w) cmp(regRdata, d);
  endtask
  task automatic hw(input logic exp);
    @(posedge clk_sys);
    hwClearReq <= 1'b1;
    @(posedge clk_sys);
    hwClearReq <= 1'b0;
    #1;
    cmp(clearPulse, exp);
  endtask
  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(0, 8'h02, 16'h0000);
    acc(0, 8'h03, 16'h0000);
    cmp(watchdogPeriodCycles, 10);
    acc(1, 8'h02, 16'hFFFF);
    cmp(clearPulse, 0);
    cmp({userBitA, userBitB, userBitC}, 3'h7);
    cmp(refEnable, 1);
    cmp(passThrough, 1);
    acc(0, 8'h02, 16'hFFFB);
    acc(1, 8'h03, 16'h0200);
    acc(1, 8'h02, 16'h0204);
    cmp(clearPulse, 1);
    cmp(clearValue, 16'h8000);
    acc(0, 8'h02, 16'h0200);
    hw(1);
    acc(1, 8'h03, 16'h0000);
    // enable is taken before the write, so drop it in a write of its own
    acc(1, 8'h02, 16'h0000);
    acc(1, 8'h02, 16'h0004);
    cmp(clearPulse, 0);
    cmp(clearValue, 16'h0000);
    hw(0);
    for (int i = 0; i < 4; i++) begin
      acc(1, 8'h03, 16'(2 * i + 1));
      cmp(watchdogEnable, 1);
      // period output lags the select register by one cycle
      @(posedge clk_sys);
      #1;
      cmp(watchdogPeriodCycles, 10 * i + 10);
    end
    acc(1, 8'h03, 16'h0038);
    cmp(channelSelect, 1);
    cmp(serialOutEnableN, 1);
    cmp(frameCheckEnable, 1);
    cmp(watchdogEnable, 0);
    acc(0, 8'h03, 16'h0038);
    acc(1, 8'h02, 16'h0001);
    acc(0, 8'h0B, 16'h0040);
    acc(0, 8'h20, 16'h0000);
    acc(1, 8'h02, 16'h0012);
    cmp(powerOffCondition, 1);
    acc(1, 8'h01, 16'h0001);
    cmp(powerOffCondition, 1);
    cmp(channelSelect, 0);
    acc(0, 8'h02, 16'h0002);
    acc(0, 8'h03, 16'h0000);
    summarize;
  end
  initial begin
    #100000;
    num_errors++;
    summarize;
  end
endmodule // tb_reset_select_regs
